// ### src/shs_defines.svh
// constants for the standby halt/stop controller
`ifndef SHS_DEFINES_SVH
`define SHS_DEFINES_SVH

`define SHS_ADDR_SETTLE 8'h00
`define SHS_ADDR_CFG 8'h01
`define SHS_ADDR_STATUS 8'h02

`define SHS_SETTLE_RST 3'h4
`define SHS_SETTLE_C12 3'h0
`define SHS_SETTLE_C15 3'h2
`define SHS_SETTLE_C17 3'h4

`define SHS_EXP_C12 12
`define SHS_EXP_C15 15
`define SHS_EXP_C17 17
`define SHS_EXP_RESET 15

`define SHS_CFG_RST 6'h00
`define SHS_CFG_SUB_RUN 0
`define SHS_CFG_ON_SUB 1
`define SHS_CFG_MAIN_RUN 2
`define SHS_CFG_WT_SUB 3
`define SHS_CFG_LCD_SUB 4
`define SHS_CFG_SIO_EXT 5

`define SHS_EXP_W 5
`define SHS_CNT_W 18

`endif

// ### src/shs_pkg.sv
// types for the standby halt/stop controller
`default_nettype none
`include "shs_defines.svh"

package shs_pkg;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_HALT,
      ST_WAKE,
      ST_STOP,
      ST_SETTLE
   } shs_state_t;

   typedef struct packed {
      shs_state_t state;
      logic vec;
      logic settle_rst;
      logic [2:0] rpin;
      logic rst_low;
      logic [2:0] sel;
      logic [5:0] cfg;
      logic [7:0] rdata;
      logic resume;
      logic vector;
   } shs_top_t;

   typedef struct packed {
      logic [2:0] sync;
      logic lvl;
      logic [`SHS_CNT_W-1:0] cnt;
      logic [`SHS_EXP_W-1:0] exp;
      logic busy;
      logic done;
   } shs_cnt_t;

endpackage

`default_nettype wire

// ### src/shs_settle_cnt.sv
// oscillation settle counter on clk counting synchronised rising oscillator edges
`default_nettype none
`include "shs_defines.svh"

module shs_settle_cnt (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [`SHS_EXP_W-1:0] exp,
   input wire logic osc_pin,
   output logic busy,
   output logic done
);

   shs_pkg::shs_cnt_t s;
   shs_pkg::shs_cnt_t next_s;
   logic agree;
   logic rise;
   logic [`SHS_CNT_W-1:0] target;

   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], osc_pin};
      next_s.done = 1'b0;
      agree = (s.sync[1] == s.sync[2]);
      rise = agree && s.sync[2] && !s.lvl;
      if (agree) begin
         next_s.lvl = s.sync[2];
      end
      target = `SHS_CNT_W'(1) << s.exp;
      if (start) begin
         next_s.busy = 1'b1;
         next_s.cnt = '0;
         next_s.exp = exp;
      end else if (s.busy && rise) begin
         // counts oscillator periods from oscillation start
         next_s.cnt = s.cnt + `SHS_CNT_W'(1); // R18
         if (s.cnt + `SHS_CNT_W'(1) == target) begin
            next_s.busy = 1'b0; // R18
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign done = s.done;

endmodule

`default_nettype wire

// ### src/shs_standby_ctrl.sv
// standby controller: halt and stop entry, release and peripheral gating
//
// Decided for this implementation: strobed register access and the address map.
`default_nettype none
`include "shs_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] halt request stops cpu clock, oscillator may run, ports hold
// [R2] in standby external wakes enabled only for unmasked sources
// [R3] halt on main clock, sub stopped: watch/lcd run only if main selected
// [R4] unmasked request ends halt; vectored if accept enabled else next address
// [R5] non-vectored halt release resumes within one to two clocks
// [R6] nmi ends halt and always gives vectored service
// [R7] reset during halt ends it like an ordinary reset
// [R8] stop request stops oscillator and cpu, ports hold
// [R9] pending unmasked request at standby entry leaves standby at once
// [R10] immediate stop exit waits in halt for settle time first
// [R11] in stop watch/lcd run only on running selected subsystem clock
// [R12] stop, or halt on sub with main stopped: serial only on external clock
// [R13] software should blank lcd and pick static drive before stop
// [R14] unmasked request ends stop; service after settle wait
// [R15] reset during stop runs reset sequence after settle time
// [R16] settle select resets to 04h; codes 000,010,100 only
// [R17] masked requests never release halt or stop
// [R18] settle wait counted on restarted oscillator up to power of two
module shs_standby_ctrl #(
   parameter int N_IRQ = 8,
   parameter int EXP_C12 = `SHS_EXP_C12,
   parameter int EXP_C15 = `SHS_EXP_C15,
   parameter int EXP_C17 = `SHS_EXP_C17,
   parameter int EXP_RESET = `SHS_EXP_RESET
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic halt_req,
   input wire logic stop_req,
   input wire logic [N_IRQ-1:0] irq_request_flag,
   input wire logic [N_IRQ-1:0] irq_mask_flag,
   input wire logic irq_accept_enable,
   input wire logic nmi_req,
   input wire logic reset_pin_n,
   input wire logic main_osc_pin,
   output logic cpu_clk_en,
   output logic main_osc_en,
   output logic cpu_reset_n,
   output logic resume_next,
   output logic irq_vector_go,
   output logic port_hold,
   output logic timer_en,
   output logic wdt_en,
   output logic watch_timer_en,
   output logic lcd_en,
   output logic serial_en,
   output logic [N_IRQ-1:0] ext_wake_en
);

   shs_pkg::shs_top_t s;
   shs_pkg::shs_top_t next_s;
   logic pending;
   logic settle_start;
   logic [`SHS_EXP_W-1:0] settle_exp;
   logic settle_busy;
   logic settle_done;
   logic halt_like;
   logic standby;
   logic sub_run;
   logic on_sub;
   logic main_run;

   ////////////////////////////////////////////////////////////////////////////
   // wake sources

   // masked sources never count
   assign pending = |(irq_request_flag & ~irq_mask_flag); // R17

   function automatic logic [`SHS_EXP_W-1:0] code_exp(input logic [2:0] code);
      logic [`SHS_EXP_W-1:0] e;
      e = `SHS_EXP_W'(EXP_C17);
      if (code == `SHS_SETTLE_C12) begin
         e = `SHS_EXP_W'(EXP_C12);
      end else if (code == `SHS_SETTLE_C15) begin
         e = `SHS_EXP_W'(EXP_C15);
      end
      return e;
   endfunction

   function automatic logic code_legal(input logic [2:0] code);
      return code == `SHS_SETTLE_C12 || code == `SHS_SETTLE_C15
         || code == `SHS_SETTLE_C17;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_s = s;
      next_s.resume = 1'b0;
      next_s.vector = 1'b0;
      next_s.rdata = 8'h00;
      settle_start = 1'b0;
      next_s.rpin = {s.rpin[1:0], reset_pin_n};
      if (s.rpin[1] == s.rpin[2]) begin
         next_s.rst_low = !s.rpin[2];
      end
      unique case (s.state)
         shs_pkg::ST_RUN: begin
            if (s.rst_low) begin
               next_s.state = shs_pkg::ST_RUN;
            end else if (halt_req) begin
               if (nmi_req || pending) begin
                  next_s.state = shs_pkg::ST_WAKE; // R9
                  next_s.vec = nmi_req || irq_accept_enable;
               end else begin
                  next_s.state = shs_pkg::ST_HALT; // R1
               end
            end else if (stop_req) begin
               if (pending) begin
                  // oscillator keeps running, cpu waits as in halt
                  next_s.state = shs_pkg::ST_SETTLE; // R9 R10
                  next_s.settle_rst = 1'b0;
                  next_s.vec = irq_accept_enable;
                  settle_start = 1'b1;
               end else begin
                  next_s.state = shs_pkg::ST_STOP; // R8
               end
            end
         end
         shs_pkg::ST_HALT: begin
            if (s.rst_low) begin
               next_s.state = shs_pkg::ST_RUN; // R7
            end else if (nmi_req) begin
               next_s.state = shs_pkg::ST_WAKE; // R6
               next_s.vec = 1'b1;
            end else if (pending) begin
               next_s.state = shs_pkg::ST_WAKE; // R4
               next_s.vec = irq_accept_enable;
            end
         end
         shs_pkg::ST_WAKE: begin
            next_s.state = shs_pkg::ST_RUN; // R5
            if (!s.rst_low) begin
               next_s.vector = s.vec; // R4
               next_s.resume = !s.vec; // R5
            end
         end
         shs_pkg::ST_STOP: begin
            if (s.rst_low) begin
               next_s.state = shs_pkg::ST_SETTLE; // R15
               next_s.settle_rst = 1'b1;
               settle_start = 1'b1;
            end else if (pending) begin
               next_s.state = shs_pkg::ST_SETTLE; // R14
               next_s.settle_rst = 1'b0;
               next_s.vec = irq_accept_enable;
               settle_start = 1'b1;
            end
         end
         shs_pkg::ST_SETTLE: begin
            if (s.rst_low) begin
               next_s.settle_rst = 1'b1;
            end
            if (settle_done) begin
               next_s.state = shs_pkg::ST_RUN; // R10
               if (!s.settle_rst && !s.rst_low) begin
                  next_s.vector = s.vec; // R14
                  next_s.resume = !s.vec;
               end
            end
         end
      endcase
      settle_exp = next_s.settle_rst ? `SHS_EXP_W'(EXP_RESET) : code_exp(s.sel);
      if (reg_wr && reg_addr == `SHS_ADDR_SETTLE && code_legal(reg_wdata[2:0])) begin
         next_s.sel = reg_wdata[2:0]; // R16
      end
      if (reg_wr && reg_addr == `SHS_ADDR_CFG) begin
         next_s.cfg = reg_wdata[5:0];
      end
      if (reg_rd) begin
         if (reg_addr == `SHS_ADDR_SETTLE) begin
            next_s.rdata = {5'h00, s.sel};
         end else if (reg_addr == `SHS_ADDR_CFG) begin
            next_s.rdata = {2'h0, s.cfg};
         end else if (reg_addr == `SHS_ADDR_STATUS) begin
            next_s.rdata = {3'h0, s.rst_low, settle_busy, 3'(s.state)};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s.state <= shs_pkg::ST_RUN;
         s.vec <= 1'b0;
         s.settle_rst <= 1'b0;
         s.rpin <= 3'h7;
         s.rst_low <= 1'b0;
         s.sel <= `SHS_SETTLE_RST; // R16
         s.cfg <= `SHS_CFG_RST;
         s.rdata <= 8'h00;
         s.resume <= 1'b0;
         s.vector <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   shs_settle_cnt u_settle (
      .clk(clk),
      .rst_n(rst_n),
      .start(settle_start),
      .exp(settle_exp),
      .osc_pin(main_osc_pin),
      .busy(settle_busy),
      .done(settle_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // outputs and peripheral gating

   assign sub_run = s.cfg[`SHS_CFG_SUB_RUN];
   assign on_sub = s.cfg[`SHS_CFG_ON_SUB];
   assign main_run = s.cfg[`SHS_CFG_MAIN_RUN];
   assign halt_like = s.state == shs_pkg::ST_HALT || s.state == shs_pkg::ST_SETTLE
      || s.state == shs_pkg::ST_WAKE;
   assign standby = halt_like || s.state == shs_pkg::ST_STOP;

   assign reg_rdata = s.rdata;
   assign resume_next = s.resume;
   assign irq_vector_go = s.vector;
   assign cpu_clk_en = s.state == shs_pkg::ST_RUN; // R1 R8
   assign port_hold = standby; // R1 R8
   assign cpu_reset_n = !(s.rst_low || (s.state == shs_pkg::ST_SETTLE && s.settle_rst)); // R15
   assign main_osc_en = !(s.state == shs_pkg::ST_STOP
      || (s.state == shs_pkg::ST_HALT && on_sub && !main_run)); // R8
   assign ext_wake_en = standby ? ~irq_mask_flag : {N_IRQ{1'b1}}; // R2
   assign timer_en = !standby || (halt_like && !on_sub && sub_run);
   assign wdt_en = !standby || (halt_like && !on_sub);

   always_comb begin
      watch_timer_en = 1'b1;
      lcd_en = 1'b1;
      serial_en = 1'b1;
      if (s.state == shs_pkg::ST_STOP) begin
         watch_timer_en = sub_run && s.cfg[`SHS_CFG_WT_SUB]; // R11
         lcd_en = sub_run && s.cfg[`SHS_CFG_LCD_SUB]; // R11
         serial_en = s.cfg[`SHS_CFG_SIO_EXT]; // R12
      end else if (halt_like && !on_sub && !sub_run) begin
         watch_timer_en = !s.cfg[`SHS_CFG_WT_SUB]; // R3
         lcd_en = !s.cfg[`SHS_CFG_LCD_SUB]; // R3
      end else if (halt_like && on_sub && !main_run) begin
         watch_timer_en = s.cfg[`SHS_CFG_WT_SUB];
         lcd_en = s.cfg[`SHS_CFG_LCD_SUB];
         serial_en = s.cfg[`SHS_CFG_SIO_EXT]; // R12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_halt_entry: assert property ( // R1
      s.state == shs_pkg::ST_RUN && !s.rst_low && halt_req && !pending && !nmi_req
      |=> s.state == shs_pkg::ST_HALT && !cpu_clk_en && port_hold)
      else $error("halt entry failed");
   chk_ext_wake: assert property ( // R2
      standby |-> ext_wake_en == ~irq_mask_flag)
      else $error("external wake enable ignores mask");
   chk_watch_main: assert property ( // R3
      s.state == shs_pkg::ST_HALT && !on_sub && !sub_run
      |-> watch_timer_en == !s.cfg[`SHS_CFG_WT_SUB])
      else $error("watch timer gating in halt wrong");
   chk_halt_vector: assert property ( // R4
      s.state == shs_pkg::ST_HALT && !s.rst_low && !nmi_req && pending
      |=> ##1 (irq_vector_go == $past(irq_accept_enable, 2)) && resume_next != irq_vector_go)
      else $error("halt release service choice wrong");
   chk_wake_latency: assert property ( // R5
      s.state == shs_pkg::ST_HALT && !s.rst_low && (pending || nmi_req)
      |=> !cpu_clk_en ##1 cpu_clk_en && (resume_next || irq_vector_go))
      else $error("halt wake latency wrong");
   chk_nmi_vector: assert property ( // R6
      s.state == shs_pkg::ST_HALT && !s.rst_low && nmi_req |=> ##1 irq_vector_go)
      else $error("nmi did not vector");
   chk_halt_reset: assert property ( // R7
      s.state == shs_pkg::ST_HALT && s.rst_low |=> cpu_clk_en && !cpu_reset_n)
      else $error("reset did not end halt");
   chk_stop_entry: assert property ( // R8
      s.state == shs_pkg::ST_RUN && !s.rst_low && !halt_req && stop_req && !pending
      |=> s.state == shs_pkg::ST_STOP && !main_osc_en && !cpu_clk_en)
      else $error("stop entry failed");
   chk_immediate_exit: assert property ( // R9
      s.state == shs_pkg::ST_RUN && !s.rst_low && !halt_req && stop_req && pending
      |=> s.state == shs_pkg::ST_SETTLE && main_osc_en && !cpu_clk_en)
      else $error("pending request did not leave stop");
   chk_settle_hold: assert property ( // R10
      s.state == shs_pkg::ST_SETTLE && !settle_done |=> !cpu_clk_en)
      else $error("cpu ran before settle time");
   chk_stop_watch: assert property ( // R11
      s.state == shs_pkg::ST_STOP
      |-> watch_timer_en == (sub_run && s.cfg[`SHS_CFG_WT_SUB]) && !timer_en && !wdt_en)
      else $error("stop peripheral gating wrong");
   chk_stop_serial: assert property ( // R12
      s.state == shs_pkg::ST_STOP |-> serial_en == s.cfg[`SHS_CFG_SIO_EXT])
      else $error("serial gating in stop wrong");
   chk_stop_wake: assert property ( // R14
      s.state == shs_pkg::ST_STOP && !s.rst_low && pending
      |=> s.state == shs_pkg::ST_SETTLE && settle_busy && !resume_next && !irq_vector_go)
      else $error("stop release skipped settle wait");
   chk_stop_reset: assert property ( // R15
      s.state == shs_pkg::ST_STOP && s.rst_low
      |=> s.state == shs_pkg::ST_SETTLE && !cpu_reset_n)
      else $error("reset in stop skipped settle wait");
   chk_sel_legal: assert property ( // R16
      s.sel == `SHS_SETTLE_C12 || s.sel == `SHS_SETTLE_C15 || s.sel == `SHS_SETTLE_C17)
      else $error("illegal settle code stored");
   chk_masked_hold: assert property ( // R17
      s.state == shs_pkg::ST_HALT && !s.rst_low && !nmi_req && !pending
      |=> s.state == shs_pkg::ST_HALT)
      else $error("masked request released halt");
   chk_settle_source: assert property ( // R18
      settle_done |-> s.state == shs_pkg::ST_SETTLE && !settle_busy)
      else $error("settle done outside wait");

   cov_halt_wake: cover property (
      s.state == shs_pkg::ST_HALT ##1 s.state == shs_pkg::ST_WAKE ##1 resume_next);
   cov_stop_vector: cover property (
      s.state == shs_pkg::ST_SETTLE && settle_done && s.vec && !s.settle_rst);
   cov_immediate: cover property (
      s.state == shs_pkg::ST_RUN && stop_req && pending && !s.rst_low);
   cov_stop_reset: cover property (
      s.state == shs_pkg::ST_SETTLE && s.settle_rst && settle_done);

endmodule

`default_nettype wire

// ### bench/shs_osc_model.sv
// main oscillator model that stops and restarts under controller command
`default_nettype none
module shs_osc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic main_osc_en,
   output logic main_osc_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div;
   // stopped crystal rests low; running gives one period every four clocks
   always_ff @(posedge clk) begin
      if (!rst_n || !main_osc_en) begin
         div <= 2'h0;
         main_osc_pin <= 1'b0;
      end else begin
         div <= div + 2'h1;
         main_osc_pin <= div[1];
      end
   end
endmodule
`default_nettype wire

// ### bench/shs_standby_ctrl_test.sv
// self-checking bench for the standby controller
`default_nettype none
module shs_standby_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0;
   logic rst_n = 0;
   logic reg_wr = 0, reg_rd = 0, halt_req = 0, stop_req = 0, acc = 0, nmi = 0, rpin_n = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, req = 8'h00, mask = 8'hff, rdata, wake;
   logic cpu_clk_en, osc_en, osc_pin, cpu_rst_n, res_next, vec_go, hold;
   logic tmr, wdt, wtm, lcd, sio;
   int failures = 0;
   int checks_done = 0;
   int exp_q[$];
   integer seed = 32'h0000_8f16;
   always #4 clk = ~clk;
   shs_standby_ctrl #(.EXP_C15(3), .EXP_C17(4), .EXP_RESET(3))
      shs_standby_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .halt_req(halt_req),
      .stop_req(stop_req), .irq_request_flag(req), .irq_mask_flag(mask),
      .irq_accept_enable(acc), .nmi_req(nmi), .reset_pin_n(rpin_n), .main_osc_pin(osc_pin),
      .cpu_clk_en(cpu_clk_en), .main_osc_en(osc_en), .cpu_reset_n(cpu_rst_n),
      .resume_next(res_next), .irq_vector_go(vec_go), .port_hold(hold), .timer_en(tmr),
      .wdt_en(wdt), .watch_timer_en(wtm), .lcd_en(lcd), .serial_en(sio),
      .ext_wake_en(wake));
   shs_osc_model shs_osc_model_inst (.clk(clk), .rst_n(rst_n), .main_osc_en(osc_en),
      .main_osc_pin(osc_pin));
   ////////////////////////////////////////
   task automatic ck(string what, logic [7:0] got, logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic go(logic stop);
      @(posedge clk);
      halt_req <= !stop;
      stop_req <= stop;
      @(posedge clk);
      halt_req <= 1'b0;
      stop_req <= 1'b0;
      #1;
   endtask
   task automatic irq(logic [7:0] r, logic [7:0] m, logic a, logic nm);
      @(posedge clk);
      req <= r;
      mask <= m;
      acc <= a;
      nmi <= nm;
      #1;
   endtask
   // model queue holds the expected wake kind: 1 next address, 2 vectored
   task automatic wait_res(int lo, int hi);
      int n;
      int e;
      n = 0;
      e = exp_q.pop_front();
      while (res_next !== 1'b1 && vec_go !== 1'b1 && n < hi) begin
         cyc(1);
         n++;
      end
      ck("wake kind", {6'h00, vec_go, res_next}, e[7:0]);
      ck("wake time", 8'(n >= lo && n < hi), 8'h01);
      if (n == hi) results();
   endtask
   ////////////////////////////////////////
   initial begin
      int b;
      int e;
      logic [7:0] v;
      logic [7:0] m;
      logic [7:0] s;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, v);
      ck("settle reset", v, 8'h04);
      rd(8'h01, v);
      ck("cfg reset", v, 8'h00);
      wr(8'h00, 8'h03);
      rd(8'h00, v);
      ck("settle illegal", v, 8'h04);
      rd(8'h33, v);
      ck("unmapped", v, 8'h00);
      ck("wake run", wake, 8'hff);
      for (int k = 0; k < 3; k++) begin
         b = $unsigned($random(seed)) % 8;
         m = $random(seed) | (8'h01 << b);
         v = $random(seed);
         // last pass halts on the sub clock with the main clock stopped
         wr(8'h01, k == 2 ? {2'h0, v[5:3], 3'h2} : {3'h0, v[4:3], 3'h0});
         go(1'b0);
         ck("cpu clk halt", {7'h00, cpu_clk_en}, 8'h00);
         ck("port hold", {7'h00, hold}, 8'h01);
         ck("watch halt", {7'h00, wtm}, {7'h00, v[3] ^ (k != 2)});
         ck("lcd halt", {7'h00, lcd}, {7'h00, v[4] ^ (k != 2)});
         ck("halt gates", {4'h0, osc_en, sio, tmr, wdt},
            k == 2 ? {5'h00, v[5], 2'h0} : 8'h0d);
         rd(8'h02, s);
         ck("status halt", s, 8'h01);
         irq(8'h01 << b, m, k[0], 1'b0);
         cyc(6);
         ck("masked holds", {7'h00, cpu_clk_en}, 8'h00);
         ck("wake gate", wake, ~m);
         exp_q.push_back(k == 0 ? 1 : 2);
         irq(8'h01 << b, k == 2 ? m : m & ~(8'h01 << b), k == 1, k == 2);
         wait_res(1, 4);
         ck("cpu clk run", {7'h00, cpu_clk_en}, 8'h01);
         irq(8'h00, 8'hff, 1'b0, 1'b0);
      end
      irq(8'h01 << b, 8'h00, 1'b0, 1'b0);
      exp_q.push_back(1);
      go(1'b0);
      wait_res(0, 4);
      irq(8'h00, 8'hff, 1'b0, 1'b0);
      for (int k = 0; k < 3; k++) begin
         e = 4 << (k == 0 ? 12 : k + 2);
         b = $unsigned($random(seed)) % 8;
         v = $random(seed);
         wr(8'h01, {2'h0, v[5:0]});
         wr(8'h00, 8'(2 * k));
         // random cfg and settle code 000, 010, 100 in turn written before stop; lcd not blanked
         go(1'b1);
         ck("osc stop", {7'h00, osc_en}, 8'h00);
         ck("gates stop", {6'h00, tmr, wdt}, 8'h00);
         ck("watch stop", {7'h00, wtm}, {7'h00, v[0] & v[3]});
         ck("lcd stop", {7'h00, lcd}, {7'h00, v[0] & v[4]});
         ck("sio stop", {7'h00, sio}, {7'h00, v[5]});
         exp_q.push_back(k == 1 ? 2 : 1);
         irq(8'h01 << b, ~(8'h01 << b), k == 1, 1'b0);
         wait_res(e - 4, e + 20);
         irq(8'h00, 8'hff, 1'b0, 1'b0);
      end
      irq(8'h01 << b, 8'h00, 1'b0, 1'b0);
      exp_q.push_back(1);
      go(1'b1);
      wait_res(56, 100);
      irq(8'h00, 8'hff, 1'b0, 1'b0);
      go(1'b0);
      @(posedge clk) rpin_n <= 1'b0;
      cyc(8);
      ck("rst halt", {6'h00, cpu_rst_n, cpu_clk_en}, 8'h01);
      @(posedge clk) rpin_n <= 1'b1;
      cyc(8);
      ck("rst halt end", {7'h00, cpu_rst_n}, 8'h01);
      go(1'b1);
      @(posedge clk) rpin_n <= 1'b0;
      cyc(8);
      @(posedge clk) rpin_n <= 1'b1;
      cyc(8);
      ck("rst stop wait", {7'h00, cpu_rst_n}, 8'h00);
      b = 0;
      while (cpu_rst_n !== 1'b1 && b < 80) begin
         cyc(1);
         b++;
      end
      ck("rst stop end", 8'(b > 8 && b < 80), 8'h01);
      results();
   end
   initial begin
      #400000;
      failures++;
      results();
   end
endmodule
`default_nettype wire
